// ==== src/pbmcs_cfg.svh ====
// constants for the bridge mode, bus clock and sideband block
`ifndef PBMCS_CFG_SVH
`define PBMCS_CFG_SVH

`define PBMCS_MCLK_MHZ       50
`define PBMCS_BUSCLK_MHZ     25
`define PBMCS_BUSCLK_MIN_MHZ 20
`define PBMCS_BUSCLK_MAX_MHZ 33
`define PBMCS_BUSCLK_HI_MHZ  66
`define PBMCS_CLKDIV_HALF    (`PBMCS_MCLK_MHZ / (2 * `PBMCS_BUSCLK_MHZ))
`define PBMCS_DIV_W          4
`define PBMCS_BOOT_W         2
`define PBMCS_SYNC_STAGES    2

`define PBMCS_SYNC_W   5
`define PBMCS_MS_MODE  0
`define PBMCS_MS_FAST  1
`define PBMCS_MS_CRUN  2
`define PBMCS_MS_PME   3
`define PBMCS_MS_MACT  4
`define PBMCS_MS_RST   5'h14
`define PBMCS_BS_EN    0
`define PBMCS_BS_PERF  1
`define PBMCS_BS_WAKE  2
`define PBMCS_BS_CLR   3
`define PBMCS_BS_CRUN  4
`define PBMCS_BS_RST   5'h10

`endif

// ==== src/pbmcs_pkg.sv ====
// types for the bridge mode, bus clock and sideband block
package pbmcs_pkg;
  typedef enum logic {
    PBMCS_BOOT_WAIT,
    PBMCS_BOOT_HELD
  } pbmcs_boot_t;
endpackage : pbmcs_pkg

// ==== src/pbmcs_sync.sv ====
// two-flop level synchroniser, one lane per bit
module pbmcs_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      // first stage feeds only the second stage
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[i] <= RST_VAL[i];
          q[i]        <= RST_VAL[i];
        end else if (en) begin
          meta_reg[i] <= d[i];
          q[i]        <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : pbmcs_sync

// ==== src/pbmcs_top.sv ====
// bridge mode strap, bus clock drive and bus sideband pins
// Overview of operation
// R01: strap high selects host bridge and turns the on-chip arbiter on.
// R02: strap low selects guest bridge and keeps the arbiter off.
// R03: host mode drives bus clock out; board loops it back to the clock input.
// R04: guest mode leaves bus clock out unused; timing comes from the host's clock.
// R05: all bus signals are sampled only on rising bus clock edges; the mini active and fast bus enable inputs are sampled on mclk instead.
// R06: bus clock logic works from 20 to 33 MHz and at 66 MHz.
// R07: clock-run pin is only a request input; never driven.
// R08: open-drain mini active output low while full performance is needed.
// R09: wake-up event pulls the open-drain power event output low.
// R10: outside party asserts fast bus enable when the segment runs at 66 MHz.
// R11: strap level captured at reset release and held until next reset.
`include "pbmcs_cfg.svh"

module pbmcs_top
  import pbmcs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic bus_clk,
  input  wire logic bridge_mode_select,
  input  wire logic fast_bus_enable,
  input  wire logic clock_run_request_n_i,
  output logic      clock_run_request_n_o,
  output logic      clock_run_request_n_oe,
  input  wire logic mini_bus_active_n_i,
  output logic      mini_bus_active_n_o,
  output logic      mini_bus_active_n_oe,
  output logic      power_event_n_o,
  output logic      power_event_n_oe,
  output logic      bus_clock_out_zero,
  input  wire logic full_perf_req,
  input  wire logic wake_event,
  input  wire logic pme_clear,
  output logic      host_mode,
  output logic      arbiter_enable,
  output logic      mode_captured,
  output logic      fast_bus_seen,
  output logic      clock_run_seen,
  output logic      mini_bus_busy,
  output logic      power_event_pending
);

  localparam logic [`PBMCS_DIV_W-1:0]  DIV_LAST  = `PBMCS_DIV_W'(`PBMCS_CLKDIV_HALF - 1);
  // capture one edge after the second stage has loaded the post-release strap level
  localparam logic [`PBMCS_BOOT_W-1:0] BOOT_LAST = `PBMCS_BOOT_W'(`PBMCS_SYNC_STAGES);

  // ---------------- system clock domain ----------------
  logic [`PBMCS_SYNC_W-1:0] ms_d;
  logic [`PBMCS_SYNC_W-1:0] ms_q;
  pbmcs_boot_t              boot_reg;
  pbmcs_boot_t              boot_next;
  logic [`PBMCS_BOOT_W-1:0] boot_cnt_reg;
  logic [`PBMCS_BOOT_W-1:0] boot_cnt_next;
  logic                     host_reg;
  logic                     host_next;
  logic [`PBMCS_DIV_W-1:0]  div_cnt_reg;
  logic [`PBMCS_DIV_W-1:0]  div_cnt_next;
  logic                     clk_out_reg;
  logic                     clk_out_next;
  logic                     perf_reg;
  logic                     wake_tog_reg;
  logic                     clr_tog_reg;
  logic                     boot_done;
  logic                     div_wrap;
  logic                     host_run;

  // bus-domain signals
  logic                     bus_rst_b;
  logic [`PBMCS_SYNC_W-1:0] bs_d;
  logic [`PBMCS_SYNC_W-1:0] bs_q;
  logic                     bus_en;
  logic                     wake_prev_reg;
  logic                     clr_prev_reg;
  logic                     pme_reg;
  logic                     pme_next;
  logic                     act_reg;
  logic                     crun_reg;
  logic                     wake_pulse;
  logic                     clr_pulse;

  assign ms_d[`PBMCS_MS_MODE] = bridge_mode_select;
  assign ms_d[`PBMCS_MS_FAST] = fast_bus_enable;
  assign ms_d[`PBMCS_MS_CRUN] = crun_reg;
  assign ms_d[`PBMCS_MS_PME]  = pme_reg;
  assign ms_d[`PBMCS_MS_MACT] = mini_bus_active_n_i;

  pbmcs_sync #(
    .WIDTH   (`PBMCS_SYNC_W),
    .RST_VAL (`PBMCS_MS_RST)
  ) u_sync_sys (
    .clk   (mclk),
    .rst_b (rst_b),
    .en    (clk_en),
    .d     (ms_d),
    .q     (ms_q)
  );

  // R11 strap sampled once the synchroniser holds post-release levels
  assign boot_done     = (boot_reg == PBMCS_BOOT_WAIT) && (boot_cnt_reg == BOOT_LAST);
  assign boot_cnt_next = (boot_reg == PBMCS_BOOT_WAIT) ? boot_cnt_reg + 1'b1 : boot_cnt_reg;

  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      PBMCS_BOOT_WAIT: begin
        if (boot_done) begin
          boot_next = PBMCS_BOOT_HELD;
        end
      end
      PBMCS_BOOT_HELD: begin
        boot_next = PBMCS_BOOT_HELD;
      end
      default: begin
        boot_next = PBMCS_BOOT_WAIT;
      end
    endcase
  end

  // R01 R02 host and arbiter follow the captured strap level
  assign host_next = boot_done ? ms_q[`PBMCS_MS_MODE] : host_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_reg     <= PBMCS_BOOT_WAIT;
      boot_cnt_reg <= '0;
      host_reg     <= 1'b0;
    end else if (clk_en) begin
      boot_reg     <= boot_next;
      boot_cnt_reg <= boot_cnt_next;
      host_reg     <= host_next;
    end
  end

  assign host_mode      = host_reg;
  assign arbiter_enable = host_reg;
  assign mode_captured  = (boot_reg == PBMCS_BOOT_HELD);

  // R03 bus clock divided down from the system clock in host mode
  assign host_run     = mode_captured && host_reg;
  assign div_wrap     = (div_cnt_reg == DIV_LAST);
  assign div_cnt_next = (!host_run || div_wrap) ? '0 : div_cnt_reg + 1'b1;
  // R04 output parked low in guest mode
  assign clk_out_next = host_run ? (clk_out_reg ^ div_wrap) : 1'b0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= '0;
      clk_out_reg <= 1'b0;
    end else if (clk_en) begin
      div_cnt_reg <= div_cnt_next;
      clk_out_reg <= clk_out_next;
    end
  end

  assign bus_clock_out_zero = clk_out_reg;

  // events cross as toggles so a stalled bus clock cannot drop them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      perf_reg     <= 1'b0;
      wake_tog_reg <= 1'b0;
      clr_tog_reg  <= 1'b0;
    end else if (clk_en) begin
      perf_reg     <= full_perf_req;
      wake_tog_reg <= wake_tog_reg ^ wake_event;
      clr_tog_reg  <= clr_tog_reg ^ pme_clear;
    end
  end

  assign fast_bus_seen       = ms_q[`PBMCS_MS_FAST];
  assign clock_run_seen      = !ms_q[`PBMCS_MS_CRUN];
  assign power_event_pending = ms_q[`PBMCS_MS_PME];
  assign mini_bus_busy       = !ms_q[`PBMCS_MS_MACT];

  // R07 clock-run is never driven
  assign clock_run_request_n_o  = 1'b0;
  assign clock_run_request_n_oe = 1'b0;

  // ---------------- bus clock domain ----------------
  // R06 bus logic is plain registers with no timing tied to the clock rate
  pbmcs_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_sync_rst (
    .clk   (bus_clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .d     (1'b1),
    .q     (bus_rst_b)
  );

  assign bs_d[`PBMCS_BS_EN]   = clk_en;
  assign bs_d[`PBMCS_BS_PERF] = perf_reg;
  assign bs_d[`PBMCS_BS_WAKE] = wake_tog_reg;
  assign bs_d[`PBMCS_BS_CLR]  = clr_tog_reg;
  assign bs_d[`PBMCS_BS_CRUN] = clock_run_request_n_i;

  // R05 pins and crossings sampled on rising bus clock edges
  pbmcs_sync #(
    .WIDTH   (`PBMCS_SYNC_W),
    .RST_VAL (`PBMCS_BS_RST)
  ) u_sync_bus (
    .clk   (bus_clk),
    .rst_b (bus_rst_b),
    .en    (1'b1),
    .d     (bs_d),
    .q     (bs_q)
  );

  assign bus_en     = bs_q[`PBMCS_BS_EN];
  assign wake_pulse = bs_q[`PBMCS_BS_WAKE] ^ wake_prev_reg;
  assign clr_pulse  = bs_q[`PBMCS_BS_CLR] ^ clr_prev_reg;
  // R09 wake sets the pending event; a set beats a clear in the same cycle
  assign pme_next   = wake_pulse | (pme_reg & ~clr_pulse);

  always_ff @(posedge bus_clk or negedge bus_rst_b) begin
    if (!bus_rst_b) begin
      wake_prev_reg <= 1'b0;
      clr_prev_reg  <= 1'b0;
      pme_reg       <= 1'b0;
      act_reg       <= 1'b0;
      crun_reg      <= 1'b1;
    end else if (bus_en) begin
      wake_prev_reg <= bs_q[`PBMCS_BS_WAKE];
      clr_prev_reg  <= bs_q[`PBMCS_BS_CLR];
      pme_reg       <= pme_next;
      act_reg       <= bs_q[`PBMCS_BS_PERF];
      crun_reg      <= bs_q[`PBMCS_BS_CRUN];
    end
  end

  // R08 open drain: only ever pulls low
  assign mini_bus_active_n_o  = 1'b0;
  assign mini_bus_active_n_oe = act_reg;
  // R09 open drain power event
  assign power_event_n_o      = 1'b0;
  assign power_event_n_oe     = pme_reg;

  // ---------------- checks ----------------
  a_mode_held: assert property ( // R11
    @(posedge mclk) disable iff (!rst_b)
    mode_captured |=> $stable(host_mode) && mode_captured)
    else $error("mode changed after capture");

  a_host_strap: assert property ( // R01
    @(posedge mclk) disable iff (!rst_b)
    (boot_done && clk_en && ms_q[`PBMCS_MS_MODE]) |=> host_mode && arbiter_enable)
    else $error("strap high did not select host with arbiter");

  a_guest_strap: assert property ( // R02
    @(posedge mclk) disable iff (!rst_b)
    (boot_done && clk_en && !ms_q[`PBMCS_MS_MODE]) |=> !host_mode && !arbiter_enable)
    else $error("strap low did not select guest without arbiter");

  a_clk_toggle: assert property ( // R03
    @(posedge mclk) disable iff (!rst_b)
    (host_run && clk_en && div_wrap) |=> bus_clock_out_zero != $past(bus_clock_out_zero))
    else $error("bus clock out did not toggle");

  a_guest_clk_low: assert property ( // R04
    @(posedge mclk) disable iff (!rst_b)
    (mode_captured && !host_mode) |-> !bus_clock_out_zero)
    else $error("bus clock out driven in guest mode");

  a_crun_undriven: assert property ( // R07
    @(posedge mclk) disable iff (!rst_b)
    !clock_run_request_n_oe)
    else $error("clock-run pin driven");

  a_active_follow: assert property ( // R08
    @(posedge bus_clk) disable iff (!bus_rst_b)
    bus_en |=> mini_bus_active_n_oe == $past(bs_q[`PBMCS_BS_PERF]))
    else $error("mini active does not follow the request");

  a_wake_pme: assert property ( // R09
    @(posedge bus_clk) disable iff (!bus_rst_b)
    (wake_pulse && bus_en) |=> power_event_n_oe && !power_event_n_o)
    else $error("wake event did not pull power event low");

  a_pme_hold: assert property ( // R09
    @(posedge bus_clk) disable iff (!bus_rst_b)
    (power_event_n_oe && !clr_pulse) |=> power_event_n_oe)
    else $error("power event released without clear");

  a_bus_sample: assert property ( // R05
    @(posedge bus_clk) disable iff (!bus_rst_b)
    !bus_en |=> $stable(pme_reg) && $stable(act_reg) && $stable(crun_reg))
    else $error("bus state moved while frozen");

  a_pme_clear: assert property ( // R09
    @(posedge bus_clk) disable iff (!bus_rst_b)
    (bus_en && clr_pulse && !wake_pulse) |=> !power_event_n_oe)
    else $error("power event not released by clear");

  a_clk_frozen: assert property ( // R03
    @(posedge mclk) disable iff (!rst_b)
    !clk_en |=> $stable(bus_clock_out_zero) && $stable(host_mode))
    else $error("bus clock out moved while frozen");

  a_mode_early: assert property ( // R11
    @(posedge mclk) disable iff (!rst_b)
    !mode_captured |-> !host_mode && !bus_clock_out_zero)
    else $error("mode or bus clock active before capture");

endmodule : pbmcs_top

// ==== dv/pbmcs_partner.sv ====
// far side model: bus host clock, pulled-up sideband wires
module pbmcs_partner (
  input  wire logic host_clk_on,
  input  wire logic crun_req,
  input  wire logic dev_busy,
  input  wire logic bus_clock_out_zero,
  input  wire logic crun_oe,
  input  wire logic mact_oe,
  input  wire logic pme_oe,
  input  wire logic crun_o,
  input  wire logic mact_o,
  input  wire logic pme_o,
  output logic      bus_clk,
  output logic      crun_w,
  output logic      mact_w,
  output logic      pme_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gen_clk = 1'b0;
  // host clock, stands still when off
  always begin
    #24;
    gen_clk = host_clk_on & ~gen_clk;
  end
  assign bus_clk = host_clk_on ? gen_clk : bus_clock_out_zero;
  // card pulls the wire low to ask for clock
  assign crun_w = (crun_req || (crun_oe && !crun_o)) ? 1'b0 : 1'b1;
  // pulled-up wires, any party pulls low, released wire floats high
  assign mact_w = (dev_busy || (mact_oe && !mact_o)) ? 1'b0 : 1'b1;
  assign pme_w = (pme_oe && !pme_o) ? 1'b0 : 1'b1;
endmodule : pbmcs_partner

// ==== dv/testbench.sv ====
// self-checking bench for bridge mode, bus clock and sideband block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, strap = 1'b0;
  logic fast = 1'b0, perf = 1'b0, wake = 1'b0, clr = 1'b0;
  logic hc = 1'b0, crun_req = 1'b0, dev_busy = 1'b0, a;
  logic bus_clk, crun_w, mact_w, pme_w, crun_oe, mact_oe, pme_oe;
  logic bclk, host, arb, capt, fast_seen, crun_seen, busy, pend;
  logic crun_o, mact_o, pme_o;
  logic [5:0] obs;
  localparam int PME = 5, PEND = 4, MACT = 3, BUSY = 2, CRUN = 1, FAST = 0;
  assign obs = {pme_oe, pend, mact_oe, busy, crun_seen, fast_seen};
  int errors = 0, checked = 0, cycles = 0;
  always #10 mclk = ~mclk;
  pbmcs_top pbmcs_top_inst (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .bus_clk(bus_clk),
    .bridge_mode_select(strap), .fast_bus_enable(fast),
    .clock_run_request_n_i(crun_w), .clock_run_request_n_o(crun_o),
    .clock_run_request_n_oe(crun_oe), .mini_bus_active_n_i(mact_w),
    .mini_bus_active_n_o(mact_o), .mini_bus_active_n_oe(mact_oe),
    .power_event_n_o(pme_o), .power_event_n_oe(pme_oe),
    .bus_clock_out_zero(bclk), .full_perf_req(perf), .wake_event(wake),
    .pme_clear(clr), .host_mode(host), .arbiter_enable(arb),
    .mode_captured(capt), .fast_bus_seen(fast_seen),
    .clock_run_seen(crun_seen), .mini_bus_busy(busy),
    .power_event_pending(pend));
  pbmcs_partner pbmcs_partner_inst (
    .host_clk_on(hc), .crun_req(crun_req), .dev_busy(dev_busy),
    .bus_clock_out_zero(bclk), .crun_oe(crun_oe), .mact_oe(mact_oe),
    .pme_oe(pme_oe), .crun_o(crun_o), .mact_o(mact_o), .pme_o(pme_o),
    .bus_clk(bus_clk), .crun_w(crun_w),
    .mact_w(mact_w), .pme_w(pme_w));
  task give_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task check(input string nm, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %b seen %b", nm, exp, seen);
    end
  endtask : check
  // bounded wait, sampled at the falling edge where outputs settle
  task automatic await(input int idx, input logic v, input string nm);
    int n;
    n = 0;
    while (obs[idx] !== v && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check(nm, obs[idx], v);
  endtask : await
  task do_reset(input logic s, input logic h);
    @(negedge mclk);
    rst_b = 1'b0;
    strap = s;
    hc = h;
    repeat (10) @(negedge mclk);
    check("rst pme_oe", pme_oe, 1'b0);
    check("rst mact_oe", mact_oe, 1'b0);
    check("rst capt", capt, 1'b0);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : do_reset
  task t_host;
    do_reset(1'b1, 1'b0);
    check("host", host, 1'b1);
    check("arb", arb, 1'b1);
    check("capt", capt, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = bclk;
      @(negedge mclk);
      check("bclk toggle", bclk, ~a);
    end
    clk_en = 1'b0;
    @(negedge mclk);
    a = bclk;
    repeat (3) @(negedge mclk);
    check("bclk frozen", bclk, a);
    clk_en = 1'b1;
    strap = 1'b0;
    repeat (8) @(negedge mclk);
    check("host held", host, 1'b1);
  endtask : t_host
  task t_guest;
    do_reset(1'b0, 1'b1);
    check("host", host, 1'b0);
    check("arb", arb, 1'b0);
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      check("bclk idle", bclk, 1'b0);
    end
    // freeze long enough for the bus side to see the enable drop
    clk_en = 1'b0;
    perf = 1'b1;
    repeat (20) @(negedge mclk);
    check("frozen mact", mact_oe, 1'b0);
    check("frozen bclk", bclk, 1'b0);
    clk_en = 1'b1;
    await(MACT, 1'b1, "mact after thaw");
    perf = 1'b0;
    await(MACT, 1'b0, "mact thaw rel");
    await(BUSY, 1'b0, "busy thaw rel");
  endtask : t_guest
  task t_side;
    wake = 1'b1;
    @(negedge mclk);
    wake = 1'b0;
    await(PME, 1'b1, "pme_oe set");
    check("pme wire", pme_w, 1'b0);
    await(PEND, 1'b1, "pend");
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    await(PME, 1'b0, "pme_oe clr");
    check("pme wire rel", pme_w, 1'b1);
    await(PEND, 1'b0, "pend clr");
    perf = 1'b1;
    await(MACT, 1'b1, "mact_oe");
    check("mact wire", mact_w, 1'b0);
    await(BUSY, 1'b1, "busy");
    perf = 1'b0;
    await(MACT, 1'b0, "mact rel");
    check("mact wire rel", mact_w, 1'b1);
    // busy must drop first or the next wait would pass on the stale level
    await(BUSY, 1'b0, "busy rel");
    dev_busy = 1'b1;
    await(BUSY, 1'b1, "busy other");
    dev_busy = 1'b0;
    await(BUSY, 1'b0, "busy other rel");
    crun_req = 1'b1;
    await(CRUN, 1'b1, "crun seen");
    check("crun_oe", crun_oe, 1'b0);
    crun_req = 1'b0;
    await(CRUN, 1'b0, "crun idle");
    check("crun wire", crun_w, 1'b1);
    // outside party flags a fast segment
    fast = 1'b1;
    await(FAST, 1'b1, "fast");
    fast = 1'b0;
    await(FAST, 1'b0, "fast off");
  endtask : t_side
  // runaway guard, far above the expected run of some 250 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    t_host();
    t_side();
    t_guest();
    t_side();
    give_verdict();
  end
endmodule : testbench
